//--- core/i2c_eeprom_pkg.sv
// shared constants for the i2c eeprom master
package i2c_eeprom_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL = 16'hF0B0; // control and status
  localparam logic [15:0] IDX_TGT = 16'hF0B1; // target address
  localparam logic [15:0] IDX_RXD = 16'hF0B2; // receive data
  localparam logic [15:0] IDX_TXD = 16'hF0B3; // transmit data

  // control and status field positions
  localparam int unsigned POS_RX_FULL = 7; // receive full
  localparam int unsigned POS_ERR = 5; // bus error, write 1 to clear
  localparam int unsigned POS_TX_EMPTY = 3; // transmit empty
  localparam int unsigned POS_STOP = 1; // stop after current byte

  // target address register fields
  localparam int unsigned POS_DIR = 0; // 0 write, 1 read

  // values after reset
  localparam logic [7:0] TGT_RST = 8'h00;
  localparam logic [7:0] RXD_RST = 8'h00;
  localparam logic [7:0] TXD_RST = 8'h00;

  // bus timing: one quarter of an scl bit
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned QUARTER_NS = 2500;
  localparam int unsigned QUARTER_CYC =
    (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // bit index of the acknowledge bit within a byte slot
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // link states, gray coded in the order listed
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_ADDR = 3'h3,
    ST_TX = 3'h2,
    ST_RX = 3'h6,
    ST_STOP = 3'h7,
    ST_HOLD = 3'h5
  } link_state_t;

endpackage

//--- core/bit_sync.sv
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module bit_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and synchronised level out
  input wire logic din,
  output logic dout
);

  typedef struct packed
  {
    logic meta; // first stage, read only by the second
    logic held; // second stage
  } sync_t;

  sync_t r;
  sync_t n;

  // next stage values
  always_comb
  begin
    n.meta = din;
    n.held = r.meta;
  end

  // released bus lines idle high, so reset high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= 2'h3;
    else
      r <= n;
  end

  assign dout = r.held;

endmodule

//--- core/tick_divider.sv
// free running divider giving a one-cycle enable every div cycles
`timescale 1ns/1ps
module tick_divider
#(
  parameter int unsigned DIV = 4
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // enable pulse
  output logic tick
);

  typedef struct packed
  {
    logic [15:0] cnt; // cycles since last tick
    logic pulse; // registered enable
  } div_t;

  div_t r;
  div_t n;

  // count up, wrap and pulse on the last cycle
  always_comb
  begin
    n = r;
    n.pulse = 1'b0;
    if (r.cnt == 16'(DIV - 1))
    begin
      n.cnt = 16'h0000;
      n.pulse = 1'b1;
    end
    else
      n.cnt = r.cnt + 16'h0001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= n;
  end

  assign tick = r.pulse;

endmodule

//--- core/i2c_eeprom_master.sv
// i2c eeprom master: apb registers, byte engine and open-drain pins
`timescale 1ns/1ps
module i2c_eeprom_master
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic [17:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // i2c data pin, open drain
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // i2c clock pin, open drain
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe
);

  typedef struct packed
  {
    i2c_eeprom_pkg::link_state_t state; // link state
    logic [1:0] q; // quarter within a bit
    logic [3:0] bitCnt; // bit within byte slot
    logic [8:0] shift; // byte plus ack slot
    logic smp; // sda sampled while scl high
    logic [7:0] txData; // transmit data register
    logic [7:0] tgtAddr; // target address register
    logic [7:0] rxData; // receive data register
    logic stopBit; // stop after current byte
    logic txBusy; // inverse of transmit empty
    logic rxFull; // receive full flag
    logic busErr; // bus error flag
    logic sdaLow; // pull sda low
    logic sclLow; // pull scl low
    logic [31:0] rdData; // read data caught in setup
    logic badAddr; // setup hit no register
  } master_t;

  master_t r;
  master_t n;

  logic tick; // quarter-bit enable
  logic sdaSync; // synchronised sda
  logic sclSync; // synchronised scl
  logic access; // apb access phase
  logic hitCtrl;
  logic hitTgt;
  logic hitRxd;
  logic hitTxd;
  logic txAcc; // transmit write accepted
  logic rxRd; // receive data read completes
  logic byteEnd; // last quarter of an ack slot
  logic [7:0] statusByte; // control and status read value
  logic [7:0] rdMux; // register read value

  // pins are only ever pulled low or released
  bit_sync u_sdaSync
  (
    .clk(clk),
    .rst_n(rst_n),
    .din(sdaIn),
    .dout(sdaSync)
  );

  bit_sync u_sclSync
  (
    .clk(clk),
    .rst_n(rst_n),
    .din(sclIn),
    .dout(sclSync)
  );

  // four ticks make one scl bit
  tick_divider #(.DIV(i2c_eeprom_pkg::QUARTER_CYC)) u_div
  (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // address decode, word aligned only
  assign access = psel && penable;
  assign hitCtrl = paddr[1:0] == 2'h0 &&
    paddr[17:2] == i2c_eeprom_pkg::IDX_CTRL;
  assign hitTgt = paddr[1:0] == 2'h0 &&
    paddr[17:2] == i2c_eeprom_pkg::IDX_TGT;
  assign hitRxd = paddr[1:0] == 2'h0 &&
    paddr[17:2] == i2c_eeprom_pkg::IDX_RXD;
  assign hitTxd = paddr[1:0] == 2'h0 &&
    paddr[17:2] == i2c_eeprom_pkg::IDX_TXD;

  // a new byte is taken only when idle or holding the bus in write mode;
  // in a held read the next byte is pulled by reading receive data instead
  assign txAcc = access && pwrite && hitTxd &&
    (r.state == i2c_eeprom_pkg::ST_IDLE ||
    (r.state == i2c_eeprom_pkg::ST_HOLD &&
    !r.tgtAddr[i2c_eeprom_pkg::POS_DIR]));
  assign rxRd = access && !pwrite && hitRxd;
  assign byteEnd = tick && r.q == 2'h3 && r.bitCnt == i2c_eeprom_pkg::ACK_SLOT &&
    (r.state == i2c_eeprom_pkg::ST_ADDR ||
    r.state == i2c_eeprom_pkg::ST_TX || r.state == i2c_eeprom_pkg::ST_RX);

  // status view; unlisted bits read zero
  always_comb
  begin
    statusByte = 8'h00;
    statusByte[i2c_eeprom_pkg::POS_RX_FULL] = r.rxFull;
    statusByte[i2c_eeprom_pkg::POS_ERR] = r.busErr;
    statusByte[i2c_eeprom_pkg::POS_TX_EMPTY] = !r.txBusy;
    statusByte[i2c_eeprom_pkg::POS_STOP] = r.stopBit;
  end

  // transmit data is write only and reads as zero
  assign rdMux = hitCtrl ? statusByte :
    hitTgt ? r.tgtAddr :
    hitRxd ? r.rxData : 8'h00;

  // next state: bus slave first, then the link engine, so that
  // hardware setting a flag wins over software clearing it
  always_comb
  begin
    n = r;
    // read data is caught in setup so prdata comes from a flip-flop
    if (psel && !penable)
    begin
      n.rdData = {24'h000000, rdMux};
      n.badAddr = !(hitCtrl || hitTgt || hitRxd || hitTxd);
    end
    // software writes
    if (access && pwrite && hitCtrl)
    begin
      n.stopBit = pwdata[i2c_eeprom_pkg::POS_STOP];
      if (pwdata[i2c_eeprom_pkg::POS_ERR])
        n.busErr = 1'b0;
    end
    if (access && pwrite && hitTgt)
      n.tgtAddr = pwdata[7:0];
    if (rxRd)
      n.rxFull = 1'b0;
    // quarter-bit engine
    if (tick)
    begin
      case (r.state)
        i2c_eeprom_pkg::ST_START:
        begin
          n.q = r.q + 2'h1;
          // start done: address byte with direction follows
          if (r.q == 2'h3)
          begin
            n.state = i2c_eeprom_pkg::ST_ADDR;
            n.shift = {r.tgtAddr, 1'b1};
            n.bitCnt = 4'h0;
          end
        end
        i2c_eeprom_pkg::ST_ADDR,
        i2c_eeprom_pkg::ST_TX,
        i2c_eeprom_pkg::ST_RX:
        begin
          // a slave stretching scl holds the high phase back
          if (r.q == 2'h1 && !sclSync)
            n.q = r.q;
          else
            n.q = r.q + 2'h1;
          if (r.q == 2'h2)
            n.smp = sdaSync;
          if (r.q == 2'h3)
          begin
            n.shift = {r.shift[7:0], r.smp};
            n.bitCnt = r.bitCnt + 4'h1;
          end
        end
        i2c_eeprom_pkg::ST_STOP:
        begin
          n.q = r.q + 2'h1;
          if (r.q == 2'h3)
            n.state = i2c_eeprom_pkg::ST_IDLE;
        end
        default:
          n.q = 2'h0;
      endcase
    end
    // end of a byte slot; r.smp holds the ack, high means none
    if (byteEnd)
    begin
      n.q = 2'h0;
      n.bitCnt = 4'h0;
      case (r.state)
        i2c_eeprom_pkg::ST_ADDR:
        begin
          if (r.smp)
          begin
            n.busErr = 1'b1;
            n.txBusy = 1'b0;
            n.state = i2c_eeprom_pkg::ST_STOP;
          end
          else if (r.tgtAddr[i2c_eeprom_pkg::POS_DIR])
          begin
            n.txBusy = 1'b0;
            n.state = i2c_eeprom_pkg::ST_RX;
            n.shift = 9'h1FF;
          end
          else
          begin
            n.state = i2c_eeprom_pkg::ST_TX;
            n.shift = {r.txData, 1'b1};
          end
        end
        i2c_eeprom_pkg::ST_TX:
        begin
          n.txBusy = 1'b0;
          if (r.smp)
            n.busErr = 1'b1;
          if (r.stopBit || r.smp)
            n.state = i2c_eeprom_pkg::ST_STOP;
          else
            n.state = i2c_eeprom_pkg::ST_HOLD;
        end
        default:
        begin
          n.rxData = r.shift[7:0];
          n.rxFull = 1'b1;
          if (r.stopBit)
            n.state = i2c_eeprom_pkg::ST_STOP;
          else
            n.state = i2c_eeprom_pkg::ST_HOLD;
        end
      endcase
    end
    // held read: next byte only once the last one was read
    if (r.state == i2c_eeprom_pkg::ST_HOLD &&
      r.tgtAddr[i2c_eeprom_pkg::POS_DIR] && !r.rxFull)
    begin
      n.state = i2c_eeprom_pkg::ST_RX;
      n.shift = 9'h1FF;
      n.q = 2'h0;
      n.bitCnt = 4'h0;
    end
    // accepted transmit write
    if (txAcc)
    begin
      n.txData = pwdata[7:0];
      n.txBusy = 1'b1;
      n.q = 2'h0;
      n.bitCnt = 4'h0;
      if (r.state == i2c_eeprom_pkg::ST_IDLE)
      begin
        n.state = i2c_eeprom_pkg::ST_START;
        if (r.tgtAddr[i2c_eeprom_pkg::POS_DIR])
          n.rxFull = 1'b0;
      end
      else
      begin
        // bus still held: data byte only, no start or address
        n.state = i2c_eeprom_pkg::ST_TX;
        n.shift = {pwdata[7:0], 1'b1};
      end
    end
    // pin drive follows the next state so the pins come from flip-flops
    case (n.state)
      i2c_eeprom_pkg::ST_START:
      begin
        n.sclLow = n.q == 2'h3;
        n.sdaLow = n.q[1];
      end
      i2c_eeprom_pkg::ST_ADDR,
      i2c_eeprom_pkg::ST_TX:
      begin
        n.sclLow = n.q == 2'h0 || n.q == 2'h3;
        n.sdaLow = !n.shift[8];
      end
      i2c_eeprom_pkg::ST_RX:
      begin
        n.sclLow = n.q == 2'h0 || n.q == 2'h3;
        // ack while more bytes follow, nack before the stop
        n.sdaLow = n.bitCnt == i2c_eeprom_pkg::ACK_SLOT &&
          !n.stopBit;
      end
      i2c_eeprom_pkg::ST_STOP:
      begin
        n.sclLow = n.q == 2'h0;
        n.sdaLow = !n.q[1];
      end
      i2c_eeprom_pkg::ST_HOLD:
      begin
        // scl held low keeps the slave waiting between bytes
        n.sclLow = 1'b1;
        n.sdaLow = 1'b1;
      end
      default:
      begin
        n.sclLow = 1'b0;
        n.sdaLow = 1'b0;
      end
    endcase
  end

  // all registers reset to zero: idle, empty, no error
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= n;
  end

  // apb answers in the first access cycle
  assign pready = 1'b1;
  assign prdata = r.rdData;
  assign pslverr = access && r.badAddr;

  // open drain: only ever drive low
  assign sdaOut = 1'b0;
  assign sdaOe = r.sdaLow;
  assign sclOut = 1'b0;
  assign sclOe = r.sclLow;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_txd_launch: assert property (
    txAcc && r.state == i2c_eeprom_pkg::ST_IDLE
    |=> r.state == i2c_eeprom_pkg::ST_START && r.txBusy)
    else $error("transmit write did not start a transfer");

  chk_hold_bus: assert property (
    byteEnd && !r.stopBit && !r.smp && r.state != i2c_eeprom_pkg::ST_ADDR
    |=> r.state == i2c_eeprom_pkg::ST_HOLD ##0 sclOe && sdaOe)
    else $error("bus not held after byte with stop clear");

  chk_stop_after: assert property (
    byteEnd && r.stopBit && r.state != i2c_eeprom_pkg::ST_ADDR
    |=> r.state == i2c_eeprom_pkg::ST_STOP && sclOe && sdaOe)
    else $error("no stop after byte with stop set");

  chk_start_addr: assert property (
    $fell(r.state == i2c_eeprom_pkg::ST_START)
    |-> r.state == i2c_eeprom_pkg::ST_ADDR &&
    r.shift[8:1] == $past(r.tgtAddr) && sdaOe == !r.shift[8] && sclOe)
    else $error("start not followed by address byte");

  chk_dir_select: assert property (
    byteEnd && r.state == i2c_eeprom_pkg::ST_ADDR && !r.smp
    |=> r.state == ($past(r.tgtAddr[i2c_eeprom_pkg::POS_DIR]) ?
    i2c_eeprom_pkg::ST_RX : i2c_eeprom_pkg::ST_TX))
    else $error("direction bit ignored");

  chk_txempty_clear: assert property (
    txAcc |=> r.txBusy [*2])
    else $error("transmit empty not cleared by write");

  chk_txempty_set: assert property (
    byteEnd && r.state == i2c_eeprom_pkg::ST_TX |=> !r.txBusy)
    else $error("transmit empty not set after byte");

  chk_rx_start: assert property (
    txAcc && r.state == i2c_eeprom_pkg::ST_IDLE &&
    r.tgtAddr[i2c_eeprom_pkg::POS_DIR] |=> !r.rxFull)
    else $error("receive full not cleared at read start");

  chk_rx_latch: assert property (
    byteEnd && r.state == i2c_eeprom_pkg::ST_RX
    |=> r.rxFull && r.rxData == $past(r.shift[7:0]))
    else $error("received byte not latched");

  chk_rx_readclr: assert property (
    rxRd && !byteEnd |=> !r.rxFull)
    else $error("receive read did not clear full");

  chk_seq_wait: assert property (
    r.state == i2c_eeprom_pkg::ST_HOLD && r.rxFull |=> r.state !=
    i2c_eeprom_pkg::ST_RX)
    else $error("next byte taken before read");

  chk_nack_err: assert property (
    byteEnd && r.smp && r.state != i2c_eeprom_pkg::ST_RX
    |=> r.busErr && r.state == i2c_eeprom_pkg::ST_STOP)
    else $error("missing acknowledge not flagged");

endmodule

//--- sim/eeprom_model.sv
// behavioural serial eeprom on the two-wire link, device side
`timescale 1ns/1ps
module eeprom_model
#(
  parameter logic [6:0] DEV = 7'h52, // bus address of this part
  parameter logic [7:0] FIRST = 8'hC3 // byte at the current address
)
(
  // two-wire link levels
  input wire logic scl,
  input wire logic sda,
  // open-drain pull of sda, high pulls the line low
  output logic sdaPull,
  // observations for the bench
  output logic [7:0] lastAddr,
  output logic lastAck,
  output logic [7:0] stops
);
  logic [7:0] data; // byte being served next

  // count stop conditions: sda rising while scl high
  initial stops = 8'h00;
  always @(posedge sda)
  begin
    if (scl === 1'b1)
      stops = stops + 8'h01;
  end

  // frame engine: wait for start, take the address, serve reads
  initial
  begin
    sdaPull = 1'b0;
    lastAddr = 8'h00;
    lastAck = 1'b0;
    data = FIRST;
    forever
    begin
      @(negedge sda iff scl === 1'b1);
      // sample on rising scl, msb first
      repeat (8) @(posedge scl) lastAddr = {lastAddr[6:0], sda};
      // a foreign address is left unanswered, so the master sees no ack
      if (lastAddr[7:1] == DEV)
      begin
        @(negedge scl) sdaPull = 1'b1;
        if (lastAddr[0])
        begin
          lastAck = 1'b1;
          // keep sending while the master acknowledges
          while (lastAck)
          begin
            for (int i = 7; i >= 0; i--)
              @(negedge scl) sdaPull = !data[i];
            @(negedge scl) sdaPull = 1'b0;
            @(posedge scl) lastAck = !sda;
            data = data + 8'h01;
          end
        end
        else
          @(negedge scl) sdaPull = 1'b0; // write data bytes not served
      end
    end
  end
endmodule

//--- sim/i2c_eeprom_master_tb.sv
// self-checking bench: register access, missing ack, single read
`timescale 1ns/1ps
module i2c_eeprom_master_tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sdaOut, sdaOe, sclOut, sclOe, sdaPull, lastAck, err;
  logic [7:0] lastAddr, stops, stops0;
  wire sdaW = !(sdaOe | sdaPull); // open drain with pull-up
  wire sclW = !sclOe;
  int miscompares, compares;

  i2c_eeprom_master i_i2c_eeprom_master (.clk(clk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclIn(sclW),
    .sclOut(sclOut), .sclOe(sclOe));
  eeprom_model i_eeprom_model (.scl(sclW), .sda(sdaW), .sdaPull(sdaPull),
    .lastAddr(lastAddr), .lastAck(lastAck), .stops(stops));

  // clock source
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // one apb transfer, started and ended at a rising edge
  task automatic apb(input logic wr, input logic [15:0] idx,
    input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never re-drives psel at once
    @(posedge clk);
  endtask

  // compare one value
  task automatic chk(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // read a register and compare it
  task automatic rchk(input string name, input logic [15:0] idx,
    input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(name, exp, rd);
  endtask

  // poll a status bit; the byte takes tens of thousands of cycles
  task automatic waitBit(input int pos);
    int n;
    n = 0;
    do apb(1'b0, i2c_eeprom_pkg::IDX_CTRL, 8'h00);
    while (rd[pos] !== 1'b1 && ++n < 40000);
    chk("status wait", 32'h1, {31'h0, rd[pos]});
  endtask

  // verdict, reached from the tests and from the watchdog
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog: both transfers need about 77500 cycles
  initial
  begin
    #390000;
    miscompares++;
    final_report();
  end

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 18'h00000;
    pwdata = 32'h00000000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values and access kinds; pins only ever pull low
    chk("pin out levels", 32'h0, {30'h0, sdaOut, sclOut});
    rchk("ctrl reset", i2c_eeprom_pkg::IDX_CTRL, 32'h08);
    rchk("tgt reset", i2c_eeprom_pkg::IDX_TGT, 32'h00);
    rchk("rxd reset", i2c_eeprom_pkg::IDX_RXD, 32'h00);
    apb(1'b1, i2c_eeprom_pkg::IDX_TGT, 8'hA5);
    rchk("tgt rw", i2c_eeprom_pkg::IDX_TGT, 32'hA5);
    apb(1'b1, i2c_eeprom_pkg::IDX_RXD, 8'h5A);
    rchk("rxd ro", i2c_eeprom_pkg::IDX_RXD, 32'h00);
    rchk("txd reads 0", i2c_eeprom_pkg::IDX_TXD, 32'h00);
    apb(1'b0, 16'hF0B4, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, err});
    // write to an absent device: no ack, bus error, stop
    stops0 = stops;
    apb(1'b1, i2c_eeprom_pkg::IDX_TGT, 8'h42);
    apb(1'b1, i2c_eeprom_pkg::IDX_CTRL, 8'h00);
    apb(1'b1, i2c_eeprom_pkg::IDX_TXD, 8'h3C);
    rchk("tx empty clear", i2c_eeprom_pkg::IDX_CTRL, 32'h00);
    waitBit(i2c_eeprom_pkg::POS_TX_EMPTY);
    chk("error set", 32'h28, rd);
    chk("address byte", 32'h42, {24'h0, lastAddr});
    chk("pin out busy", 32'h0, {30'h0, sdaOut, sclOut});
    repeat (3000) @(posedge clk);
    chk("stop issued", {24'h0, stops0 + 8'h01}, {24'h0, stops});
    apb(1'b1, i2c_eeprom_pkg::IDX_CTRL, 8'h00);
    rchk("w0 keeps err", i2c_eeprom_pkg::IDX_CTRL, 32'h28);
    apb(1'b1, i2c_eeprom_pkg::IDX_CTRL, 8'h20);
    rchk("w1 clears err", i2c_eeprom_pkg::IDX_CTRL, 32'h08);
    // current-address read with stop set before its only byte
    stops0 = stops;
    apb(1'b1, i2c_eeprom_pkg::IDX_TGT, 8'hA5);
    apb(1'b1, i2c_eeprom_pkg::IDX_CTRL, 8'h02);
    apb(1'b1, i2c_eeprom_pkg::IDX_TXD, 8'hFF);
    rchk("read start", i2c_eeprom_pkg::IDX_CTRL, 32'h02);
    waitBit(i2c_eeprom_pkg::POS_RX_FULL);
    chk("rx full", 32'h8A, rd);
    rchk("rx data", i2c_eeprom_pkg::IDX_RXD, 32'hC3);
    rchk("rx full cleared", i2c_eeprom_pkg::IDX_CTRL, 32'h0A);
    chk("last byte nack", 32'h0, {31'h0, lastAck});
    repeat (3000) @(posedge clk);
    chk("read stop", {24'h0, stops0 + 8'h01}, {24'h0, stops});
    chk("bus idle", 32'h3, {30'h0, sdaW, sclW});
    final_report();
  end
endmodule
